// >>> hw/pfd_route_pkg.sv
// Constants shared by the phase detector gating, test routing and oscillator forwarding logic
package pfd_route_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int          REG_AW     = 6;       // Register index width
  localparam int          REG_DW     = 24;      // Register data width; widest register is 12 bits
  localparam logic [5:0]  ADDR_PFD   = 6'h0b;   // phase_detector_ctrl_upper
  localparam logic [5:0]  ADDR_WORD  = 6'h0c;   // oscillator_word
  localparam logic [5:0]  ADDR_ROUTE = 6'h0d;   // test_route_and_forward_ctrl
  localparam logic [5:0]  ADDR_LOCK  = 6'h0f;   // lock_state, read only

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector control fields
  localparam int          PFD_W        = 12;
  localparam int          BIT_UP_GATE  = 4;     // pump_up_gate
  localparam int          BIT_DN_GATE  = 5;     // pump_down_gate
  localparam int          BIT_LD_OUT   = 6;     // lock_flag_out_en
  localparam int          BIT_FORCE_UP = 7;     // Forces up pump on
  localparam int          BIT_FORCE_DN = 8;     // Forces down pump on
  localparam int          BIT_MUTE     = 9;     // Mute when locked
  localparam logic [11:0] PFD_RESET    = 12'h870;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator word
  localparam int          WORD_W     = 10;
  localparam logic [9:0]  WORD_RESET = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Test route and forward control fields
  localparam int          ROUTE_W      = 8;
  localparam int          SEL_LSB      = 0;     // Route select [3:0]
  localparam int          SEL_W        = 4;
  localparam int          TVAL_LSB     = 4;     // Test-pin value [5:4]
  localparam int          BIT_QUARTER  = 6;     // link_clock_quarter_rate
  localparam int          BIT_AUTO     = 7;     // auto_forward_en
  localparam logic [7:0]  ROUTE_RESET  = 8'h0a;
  localparam logic [3:0]  SEL_DIRECT   = 4'ha;  // Test-pin value drives the pins
  localparam int          NUM_ROUTED   = 10;    // Codes 0..9 carry internal pairs

  ////////////////////////////////////////////////////////////////////////////
  // Link timing
  localparam logic [1:0]  DIV_LAST     = 2'h3;  // Quarter-rate divider terminal count
  localparam logic [3:0]  LAST_BIT     = 4'h9;  // Index of the tenth bit
  localparam logic [4:0]  TICKS_PER_WORD = 5'h14; // Two link ticks per bit

  typedef enum logic {ST_IDLE, ST_SHIFT} link_state_e;

endpackage

// >>> hw/pfd_gating_test_route_vco_forward.sv
// Pump gating, test-pin routing and serial forwarding of the oscillator word
// Function
// - Mute and locked: cleared gates suppress unforced pumps
// - Mute and unlocked: both pumps act freely
// - Mute clear: gates and force bits control pumps
// - Word write starts link transfer when enabled
// - Route select picks pin pair when enabled
// - Codes zero to nine route fixed pairs
// - Codes eleven to fifteen carry nothing defined
// - Code ten drives test-pin value field
// - Quarter-rate bit selects divided link clock
// - Auto-forward puts data, clock, enable out
// - Lock flag reads locked, ignores writes
// - Up and down gates reset to one
// - Lock-out enable routes lock flag out
module pfd_gating_test_route_vco_forward (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rstn_i,
  // Register port
  input  wire logic [pfd_route_pkg::REG_AW-1:0]  reg_addr_i,
  input  wire logic [pfd_route_pkg::REG_DW-1:0]  reg_wdata_i,
  input  wire logic                              reg_we_i,
  output logic      [pfd_route_pkg::REG_DW-1:0]  reg_rdata_o,
  // Phase detector
  input  wire logic                              pump_up_raw_i,
  input  wire logic                              pump_down_raw_i,
  input  wire logic                              locked_i,
  output logic                                   pump_up_o,
  output logic                                   pump_down_o,
  // Test routing
  input  wire logic                              test_pins_en_i,
  input  wire logic [pfd_route_pkg::NUM_ROUTED-1:0] test_one_src_i,
  input  wire logic [pfd_route_pkg::NUM_ROUTED-1:0] test_zero_src_i,
  // Pins
  output logic                                   test_pin_zero_o,
  output logic                                   test_pin_one_o,
  output logic                                   lock_or_serial_out_pin_o
);
  import pfd_route_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [PFD_W-1:0]   pfd_ctrl;       // Phase detector control
  logic [PFD_W-1:0]   next_pfd_ctrl;
  logic [WORD_W-1:0]  osc_word;       // Oscillator word
  logic [WORD_W-1:0]  next_osc_word;
  logic [ROUTE_W-1:0] route_ctrl;     // Route and forward control
  logic [ROUTE_W-1:0] next_route_ctrl;
  logic               lock_q;         // Sampled lock flag
  logic               next_lock_q;
  logic [REG_DW-1:0]  next_rdata;

  // Field views
  logic               mute;
  logic               up_gate;
  logic               dn_gate;
  logic [SEL_W-1:0]   route_sel;
  logic               quarter;
  logic               auto_fwd;

  assign mute      = pfd_ctrl[BIT_MUTE];
  assign up_gate   = pfd_ctrl[BIT_UP_GATE];
  assign dn_gate   = pfd_ctrl[BIT_DN_GATE];
  assign route_sel = route_ctrl[SEL_LSB +: SEL_W];
  assign quarter   = route_ctrl[BIT_QUARTER];
  assign auto_fwd  = route_ctrl[BIT_AUTO];

  // Register writes and read mux
  always_comb begin
    next_pfd_ctrl   = pfd_ctrl;
    next_osc_word   = osc_word;
    next_route_ctrl = route_ctrl;
    next_lock_q     = locked_i;
    next_rdata      = '0;
    if (reg_we_i) begin
      case (reg_addr_i)
        ADDR_PFD:   next_pfd_ctrl   = reg_wdata_i[PFD_W-1:0];
        ADDR_WORD:  next_osc_word   = reg_wdata_i[WORD_W-1:0];
        ADDR_ROUTE: next_route_ctrl = reg_wdata_i[ROUTE_W-1:0];
        default:    ;                         // Lock flag is read only
      endcase
    end
    // Reads return the stored value, zero above the field
    case (reg_addr_i)
      ADDR_PFD:   next_rdata[PFD_W-1:0]   = pfd_ctrl;
      ADDR_WORD:  next_rdata[WORD_W-1:0]  = osc_word;
      ADDR_ROUTE: next_rdata[ROUTE_W-1:0] = route_ctrl;
      ADDR_LOCK:  next_rdata[0]           = lock_q;
      default:    next_rdata              = '0;
    endcase
  end

  // Register flops; gates and lock-out enable come up set
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pfd_ctrl    <= PFD_RESET;
      osc_word    <= WORD_RESET;
      route_ctrl  <= ROUTE_RESET;
      lock_q      <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      pfd_ctrl    <= next_pfd_ctrl;
      osc_word    <= next_osc_word;
      route_ctrl  <= next_route_ctrl;
      lock_q      <= next_lock_q;
      reg_rdata_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link clock divider: free-running, gives one tick per link half period
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic       tick;

  // Full rate ticks every cycle, so the link clock tops out at half the reference
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
    tick         = !quarter || (div_cnt == DIV_LAST);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial forwarding of the oscillator word
  link_state_e        link_state;
  link_state_e        next_link_state;
  logic [WORD_W-1:0]  shift_q;        // Word being sent, MSB at the top
  logic [WORD_W-1:0]  next_shift_q;
  logic [3:0]         bit_cnt;        // Bits completed
  logic [3:0]         next_bit_cnt;
  logic               sclk_q;         // Link clock level
  logic               next_sclk_q;
  logic               start;
  logic               busy;

  // A new word write while busy restarts the transfer with the new word
  assign start = reg_we_i && (reg_addr_i == ADDR_WORD) && auto_fwd;
  assign busy  = (link_state == ST_SHIFT);

  always_comb begin
    next_link_state = link_state;
    next_shift_q    = shift_q;
    next_bit_cnt    = bit_cnt;
    next_sclk_q     = sclk_q;
    if (start) begin
      next_link_state = ST_SHIFT;
      next_shift_q    = reg_wdata_i[WORD_W-1:0];
      next_bit_cnt    = '0;
      next_sclk_q     = 1'b0;
    end else begin
      case (link_state)
        ST_SHIFT: begin
          if (tick) begin
            if (!sclk_q) begin
              // Rising edge: receiver samples the bit here
              next_sclk_q = 1'b1;
            end else begin
              // Falling edge: advance to the next bit, MSB first
              next_sclk_q  = 1'b0;
              next_shift_q = {shift_q[WORD_W-2:0], 1'b0};
              if (bit_cnt == LAST_BIT) begin
                next_link_state = ST_IDLE;    // Enable drops after bit ten
              end else begin
                next_bit_cnt = bit_cnt + 4'h1;
              end
            end
          end
        end
        ST_IDLE: ;
        default: next_link_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_state <= ST_IDLE;
      shift_q    <= '0;
      bit_cnt    <= '0;
      sclk_q     <= 1'b0;
    end else begin
      link_state <= next_link_state;
      shift_q    <= next_shift_q;
      bit_cnt    <= next_bit_cnt;
      sclk_q     <= next_sclk_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pump gating and pin steering
  logic next_pump_up;
  logic next_pump_dn;
  logic next_pin_zero;
  logic next_pin_one;
  logic next_sdo;

  always_comb begin
    // Pump gates
    if (mute) begin
      // Locked: gates decide; unlocked: both pumps free
      next_pump_up = pump_up_raw_i && (!lock_q || up_gate);
      next_pump_dn = pump_down_raw_i && (!lock_q || dn_gate);
    end else begin
      next_pump_up = pump_up_raw_i && up_gate;
      next_pump_dn = pump_down_raw_i && dn_gate;
    end
    // Force bits override gating
    next_pump_up = next_pump_up || pfd_ctrl[BIT_FORCE_UP];
    next_pump_dn = next_pump_dn || pfd_ctrl[BIT_FORCE_DN];

    // Pins
    next_pin_zero = 1'b0;
    next_pin_one  = 1'b0;
    if (auto_fwd) begin
      // Forwarding owns all three pins
      next_sdo      = busy && shift_q[WORD_W-1];
      next_pin_one  = sclk_q;
      next_pin_zero = busy;
    end else begin
      next_sdo = pfd_ctrl[BIT_LD_OUT] && lock_q;
      if (test_pins_en_i) begin
        if (route_sel < SEL_W'(NUM_ROUTED)) begin
          next_pin_one  = test_one_src_i[route_sel];
          next_pin_zero = test_zero_src_i[route_sel];
        end else if (route_sel == SEL_DIRECT) begin
          next_pin_zero = route_ctrl[TVAL_LSB];
          next_pin_one  = route_ctrl[TVAL_LSB+1];
        end else begin
          // Unused codes park the pins low
          next_pin_zero = 1'b0;
          next_pin_one  = 1'b0;
        end
      end
    end
  end

  // Output flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pump_up_o                <= 1'b0;
      pump_down_o              <= 1'b0;
      test_pin_zero_o          <= 1'b0;
      test_pin_one_o           <= 1'b0;
      lock_or_serial_out_pin_o <= 1'b0;
    end else begin
      pump_up_o                <= next_pump_up;
      pump_down_o              <= next_pump_dn;
      test_pin_zero_o          <= next_pin_zero;
      test_pin_one_o           <= next_pin_one;
      lock_or_serial_out_pin_o <= next_sdo;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] tick_cnt;               // Ticks spent in the current transfer

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= '0;
    end else if (start) begin
      tick_cnt <= '0;
    end else if (busy && tick) begin
      tick_cnt <= tick_cnt + 5'h1;
    end
  end

  AST_MUTE_LOCKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mute && lock_q && !dn_gate && !pfd_ctrl[BIT_FORCE_DN] |=> !pump_down_o)
    else $error("Down pump active while muted and locked");

  AST_MUTE_UNLOCKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mute && !lock_q && pump_up_raw_i |=> pump_up_o)
    else $error("Up pump blocked while unlocked under mute");

  AST_GATE_ONLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !mute && !pfd_ctrl[BIT_FORCE_UP] |=> pump_up_o == $past(pump_up_raw_i && up_gate))
    else $error("Up pump not following its gate");

  AST_AUTO_START: assert property (@(posedge clk_i) disable iff (!rstn_i)
    start |=> busy ##1 test_pin_zero_o)
    else $error("Word write did not start the link");

  AST_ROUTE_PAIR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    test_pins_en_i && !auto_fwd && route_sel < SEL_W'(NUM_ROUTED)
    |=> test_pin_one_o == $past(test_one_src_i[route_sel]))
    else $error("Routed pair mismatch on pin one");

  AST_DIRECT_VALUE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    test_pins_en_i && !auto_fwd && route_sel == SEL_DIRECT
    |=> test_pin_zero_o == $past(route_ctrl[TVAL_LSB]))
    else $error("Test-pin value not on pin zero");

  AST_QUARTER_RATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    busy && quarter && !tick && !start |=> $stable(sclk_q))
    else $error("Link clock moved off a quarter-rate tick");

  AST_FORWARD_PINS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    auto_fwd |=> test_pin_one_o == $past(sclk_q) && test_pin_zero_o == $past(busy))
    else $error("Forwarding pins not driven by the link");

  AST_LOCK_READ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_addr_i == ADDR_LOCK |=> reg_rdata_o[0] == $past(lock_q))
    else $error("Lock flag read mismatch");

  AST_LOCK_PIN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !auto_fwd && pfd_ctrl[BIT_LD_OUT] |=> lock_or_serial_out_pin_o == $past(lock_q))
    else $error("Lock flag not on the shared pin");

  AST_TEN_CLOCKS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    busy && (next_link_state == ST_IDLE) |-> tick_cnt == TICKS_PER_WORD - 5'h1)
    else $error("Transfer did not span ten link clocks");

endmodule

// >>> verif/vco_serial_rx.sv
// Behavioural model of the external oscillator's three-wire serial input
module vco_serial_rx (
  // Serial link from the device pins
  input  wire logic       sclk_i,
  input  wire logic       en_i,
  input  wire logic       sdata_i,
  // Last applied word and its bit count
  output logic [9:0]      word_o,
  output logic [7:0]      bits_o,
  output int              frames_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] shift_q;  // Bits gathered in the current frame
  logic [7:0] cnt_q;    // Bits gathered so far

  initial begin
    word_o = 10'h000;
    bits_o = 8'h00;
    frames_o = 0;
    shift_q = 10'h000;
    cnt_q = 8'h00;
  end

  // Capture on rising clock, apply when enable drops; empty frames ignored
  always @(posedge sclk_i, negedge en_i) begin
    if (en_i === 1'b1) begin
      shift_q <= {shift_q[8:0], sdata_i};
      cnt_q <= cnt_q + 8'h01;
    end else if (cnt_q != 8'h00) begin
      word_o <= shift_q;
      bits_o <= cnt_q;
      frames_o <= frames_o + 1;
      cnt_q <= 8'h00;
    end
  end
endmodule

// >>> verif/pfd_gating_test_route_vco_forward_tb.sv
// Self-checking bench for pump gating, test routing and word forwarding
module pfd_gating_test_route_vco_forward_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfd_route_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic                  clk_i, rstn_i, reg_we_i;
  logic [REG_AW-1:0]     reg_addr_i;
  logic [REG_DW-1:0]     reg_wdata_i, reg_rdata_o;
  logic                  pump_up_raw_i, pump_down_raw_i, locked_i, pump_up_o, pump_down_o;
  logic                  test_pins_en_i, pin_zero, pin_one, lock_pin;
  logic [NUM_ROUTED-1:0] one_src, zero_src;  // Distinct patterns per code
  logic [9:0]            rx_word;
  logic [7:0]            rx_bits;
  int                    rx_frames, n_fail, total_checks;

  pfd_gating_test_route_vco_forward pfd_gating_test_route_vco_forward_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o), .pump_up_raw_i(pump_up_raw_i),
    .pump_down_raw_i(pump_down_raw_i), .locked_i(locked_i), .pump_up_o(pump_up_o),
    .pump_down_o(pump_down_o), .test_pins_en_i(test_pins_en_i), .test_one_src_i(one_src),
    .test_zero_src_i(zero_src), .test_pin_zero_o(pin_zero), .test_pin_one_o(pin_one),
    .lock_or_serial_out_pin_o(lock_pin));

  vco_serial_rx vco_serial_rx_inst (
    .sclk_i(pin_one), .en_i(pin_zero), .sdata_i(lock_pin),
    .word_o(rx_word), .bits_o(rx_bits), .frames_o(rx_frames));

  // Reference clock, 4 ns period
  always #2 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Compare, access and closing tasks
  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {23'h0, exp}, {23'h0, got});
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One-cycle write strobe, inputs change on the falling edge
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1'b1;
    @(negedge clk_i);
    reg_we_i = 1'b0;
  endtask

  // Read data is registered: sample one edge after the address
  task automatic rd(input logic [5:0] a, input logic [23:0] exp, input string what);
    @(negedge clk_i);
    reg_addr_i = a;
    @(negedge clk_i);
    chk_val(what, exp, reg_rdata_o);
  endtask

  // Forward one word and measure the enable window in reference cycles
  task automatic xfer(input logic q, input logic [9:0] w);
    int f0;
    int len;
    int g;
    wr(ADDR_ROUTE, 24'h80 | (24'(q) << BIT_QUARTER));
    wait_cyc(2);
    f0 = rx_frames;
    len = 0;
    g = 0;
    wr(ADDR_WORD, 24'(w));
    while (pin_zero !== 1'b1 && g < 20) begin
      @(negedge clk_i);
      g++;
    end
    while (pin_zero === 1'b1 && g < 200) begin
      @(negedge clk_i);
      len++;
      g++;
    end
    if (len == 0 || g >= 200) begin
      n_fail++;
      $display("[FAIL] link enable window expected bounded seen %0d", len);
      final_report();
    end else begin
      wait_cyc(2);
      chk_val("frames", 24'(f0 + 1), 24'(rx_frames));
      chk_val("word", 24'(w), 24'(rx_word));
      chk_val("bits", 24'h00000a, 24'(rx_bits));
      // Free-running divider: first tick lands one to four cycles after the write
      if (q) chk_bit("quarter window", 1'b1, len >= 77 && len <= 80);
      else chk_val("enable cycles", 24'h000014, 24'(len));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int f0;
    {clk_i, rstn_i, reg_we_i, locked_i, test_pins_en_i} = 5'h00;
    {pump_up_raw_i, pump_down_raw_i} = 2'h3;
    reg_addr_i = 6'h00;
    reg_wdata_i = 24'h000000;
    one_src = 10'h2b5;
    zero_src = 10'h14a;
    {n_fail, total_checks} = 0;
    wait_cyc(8);
    rstn_i = 1'b1;
    rd(ADDR_PFD, 24'h000870, "pfd reset");
    rd(ADDR_WORD, 24'h000000, "word reset");
    rd(ADDR_ROUTE, 24'h00000a, "route reset");
    rd(ADDR_LOCK, 24'h000000, "lock reset");
    rd(6'h3f, 24'h000000, "unmapped");
    $display("Test reset values done");
    // Every mute, lock and gate combination
    for (int k = 0; k < 16; k++) begin
      locked_i = k[1];
      wr(ADDR_PFD, 24'h40 | (24'(k[2]) << BIT_UP_GATE) | (24'(k[3]) << BIT_DN_GATE) | (24'(k[0]) << BIT_MUTE));
      wait_cyc(3);
      chk_bit("pump up", (k[0] & ~k[1]) | k[2], pump_up_o);
      chk_bit("pump down", (k[0] & ~k[1]) | k[3], pump_down_o);
    end
    pump_up_raw_i = 1'b0;
    wait_cyc(2);
    chk_bit("pump up idle", 1'b0, pump_up_o);
    chk_bit("lock pin on", 1'b1, lock_pin);
    wr(ADDR_PFD, 24'h000030);
    wait_cyc(2);
    chk_bit("lock pin off", 1'b0, lock_pin);
    rd(ADDR_LOCK, 24'h000001, "lock set");
    wr(ADDR_LOCK, 24'h000000);
    rd(ADDR_LOCK, 24'h000001, "lock after write");
    locked_i = 1'b0;
    wait_cyc(3);
    rd(ADDR_LOCK, 24'h000000, "lock clear");
    $display("Test gating and lock done");
    // Every route code with pins enabled, test value 2
    test_pins_en_i = 1'b1;
    for (int s = 0; s < 16; s++) begin
      wr(ADDR_ROUTE, 24'(s) | 24'h20);
      wait_cyc(2);
      chk_bit("pin one", s < 10 ? one_src[s] : 1'(s == 10), pin_one);
      chk_bit("pin zero", s < 10 ? zero_src[s] : 1'b0, pin_zero);
    end
    wr(ADDR_ROUTE, 24'h00001a);
    wait_cyc(2);
    chk_val("test value", 24'h000001, {22'h0, pin_one, pin_zero});
    test_pins_en_i = 1'b0;
    wait_cyc(2);
    chk_val("pins disabled", 24'h000000, {22'h0, pin_one, pin_zero});
    $display("Test routing done");
    xfer(1'b0, 10'h2c5);
    xfer(1'b1, 10'h13a);
    wr(ADDR_ROUTE, 24'h00000a);
    wait_cyc(2);
    f0 = rx_frames;
    wr(ADDR_WORD, 24'h000255);
    wait_cyc(40);
    chk_val("no forward", 24'(f0), 24'(rx_frames));
    rd(ADDR_WORD, 24'h000255, "word readback");
    $display("Test forwarding done");
    final_report();
  end
endmodule
